// >>> core/pcg_pkg.sv
package pcg_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NGRP  = 8;
  localparam int NPROG = 2;
  localparam int PW    = 16;

  // ---------------------------------------------------------------
  // Register map (byte addresses; group register offsets are word indices)
  // ---------------------------------------------------------------
  localparam logic [11:0] A_CTRL      = 12'h000;
  localparam logic [11:0] A_STAT      = 12'h004;
  localparam logic [3:0]  GRP_BASE_HI = 4'h1;
  localparam logic [2:0]  G_CFG       = 3'h0;
  localparam logic [2:0]  G_OFF       = 3'h1;
  localparam logic [2:0]  G_WIN0      = 3'h2;
  localparam logic [2:0]  G_SP0       = 3'h3;
  localparam logic [2:0]  G_STAT      = 3'h6;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int          CTRL_PROG_BIT  = 16;
  localparam int          CFG_WVALID_LSB = 8;
  localparam int          CFG_OFF_LSB    = 0;
  localparam int          GST_EN_BIT     = 16;
  localparam int          GST_RUN_BIT    = 17;
  localparam int          GST_CHAN_LSB   = 24;
  localparam logic [7:0]  WIN_CHAN_FIRST = 8'h5b;
  localparam logic [15:0] SCALE_RST      = 16'h0168;

  typedef enum logic [2:0] {
    MODE_RESET_EN = 3'h2,
    MODE_LEVEL    = 3'h3,
    MODE_WINDOW   = 3'h4
  } pcg_mode_t;

  typedef enum logic {
    GS_IDLE = 1'b0,
    GS_RUN  = 1'b1
  } pcg_gstate_t;

  typedef struct packed {
    logic [PW-1:0] stop;
    logic [PW-1:0] start;
  } pcg_span_t;

  typedef struct packed {
    logic [2:0]       mode;
    logic [NPROG-1:0] wvalid;
    logic [PW-1:0]    offset;
  } pcg_gcfg_t;
endpackage : pcg_pkg

// >>> core/pcg_cam_groups.sv
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Reset-enable mode: armed rising edge zeroes group position, then disarms.
// - After that reset, outputs follow setpoints until the window is reached.
// - Entering idle disables outputs and re-arms the enable input.
// - Window counts as reached from forward or reverse travel.
// - Power-up position uses programmed offset; input resets are not kept.
// - Outputs may stay active up to 359 degrees after a reset.
// - Every mode is further gated by motion qualification.
// - Level mode: outputs enabled only while input high.
// - Level mode: output inside setpoints follows input level directly.
// - Level mode: position changes only by offset programming.
// - Window mode: rising edge enables outputs, position unchanged.
// - Window mode: enabled until next window start, then edge detect resumes.
// - Window mode: edges outside the window are ignored.
// - Edge modes react only to the rising edge, not high time.
// - One input window per group, channels 91 to 98.
// - Window mode: position from programmed offset, changed only by programming.
// - Window and setpoints are stored per controller program.
// - Reset-enable mode without window: active from first edge forever.
module pcg_cam_groups (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic [31:0]                   hrdata,
  output logic                          hresp,
  input  wire logic [pcg_pkg::PW-1:0]   machine_pos,
  input  wire logic [pcg_pkg::NGRP-1:0] grp_enable_in,
  input  wire logic [pcg_pkg::NGRP-1:0] motion_qualified_gating,
  output logic [pcg_pkg::NGRP-1:0]      cam_out
);

  function automatic logic in_span(pcg_pkg::pcg_span_t s, logic [pcg_pkg::PW-1:0] p);
    if (s.start <= s.stop) begin
      return (p >= s.start) && (p <= s.stop);
    end
    return (p >= s.start) || (p <= s.stop);
  endfunction : in_span

  // ---------------------------------------------------------------
  // Bus slave and global registers
  // ---------------------------------------------------------------
  logic                     wr_q, wr_d;
  logic [11:2]              waddr_q, waddr_d;
  logic [31:0]              rdata_q, rdata_d;
  logic [pcg_pkg::PW-1:0]   scale_q, scale_d;
  logic                     prog_q, prog_d;
  logic [pcg_pkg::NGRP-1:0] sync1_q, sync2_q, prev_q;
  logic [pcg_pkg::NGRP-1:0] cam_q, cam_d;
  logic [pcg_pkg::NGRP-1:0] en_vec;
  logic [31:0]              grp_rd [pcg_pkg::NGRP];
  logic                     acc;
  logic                     gwsel;

  // Zero wait states: read data is fetched in the address phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign cam_out   = cam_q;
  assign acc       = hsel && htrans[1] && hready;
  assign gwsel     = wr_q && (waddr_q[11:8] == pcg_pkg::GRP_BASE_HI);

  always_comb begin
    wr_d    = acc && hwrite;
    waddr_d = acc ? haddr[11:2] : waddr_q;
    scale_d = scale_q;
    prog_d  = prog_q;
    rdata_d = 32'h0000_0000;
    if (wr_q && ({waddr_q, 2'b00} == pcg_pkg::A_CTRL)) begin
      scale_d = hwdata[pcg_pkg::PW-1:0];
      prog_d  = hwdata[pcg_pkg::CTRL_PROG_BIT];
    end
    if (acc && !hwrite) begin
      if (haddr[11:0] == pcg_pkg::A_CTRL) begin
        rdata_d[pcg_pkg::PW-1:0]          = scale_q;
        rdata_d[pcg_pkg::CTRL_PROG_BIT]   = prog_q;
      end else if (haddr[11:0] == pcg_pkg::A_STAT) begin
        rdata_d[7:0]  = cam_q;
        rdata_d[15:8] = en_vec;
      end else if (haddr[11:8] == pcg_pkg::GRP_BASE_HI) begin
        rdata_d = grp_rd[haddr[7:5]];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q    <= 1'b0;
      waddr_q <= '0;
      rdata_q <= 32'h0000_0000;
      scale_q <= pcg_pkg::SCALE_RST;
      prog_q  <= 1'b0;
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
      cam_q   <= '0;
    end else begin
      wr_q    <= wr_d;
      waddr_q <= waddr_d;
      rdata_q <= rdata_d;
      scale_q <= scale_d;
      prog_q  <= prog_d;
      sync1_q <= grp_enable_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      cam_q   <= cam_d;
    end
  end

  // ---------------------------------------------------------------
  // Output groups
  // ---------------------------------------------------------------
  for (genvar g = 0; g < pcg_pkg::NGRP; g++) begin : g_grp
    pcg_pkg::pcg_gcfg_t     cfg_q, cfg_d;
    pcg_pkg::pcg_span_t     win_q [pcg_pkg::NPROG];
    pcg_pkg::pcg_span_t     win_d [pcg_pkg::NPROG];
    pcg_pkg::pcg_span_t     sp_q  [pcg_pkg::NPROG];
    pcg_pkg::pcg_span_t     sp_d  [pcg_pkg::NPROG];
    pcg_pkg::pcg_gstate_t   st_q, st_d;
    logic [pcg_pkg::PW-1:0] rt_off_q, rt_off_d;
    logic                   pwin_q, pwin_d;
    logic [pcg_pkg::PW:0]   sum;
    logic [pcg_pkg::PW-1:0] pos;
    logic                   sel;
    logic                   rise;
    logic                   win_hit;
    logic                   entry;
    logic                   en;
    logic [31:0]            rd;

    assign sel  = gwsel && (waddr_q[7:5] == 3'(g));
    assign rise = sync2_q[g] && !prev_q[g];
    // Offset kept below scale, so a single subtract wraps
    assign sum = {1'b0, machine_pos} + {1'b0, rt_off_q};
    assign pos = (sum >= {1'b0, scale_q}) ? pcg_pkg::PW'(sum - {1'b0, scale_q}) : sum[pcg_pkg::PW-1:0];
    // Any position inside the span counts, whichever side it came from
    assign win_hit = cfg_q.wvalid[prog_q] && in_span(win_q[prog_q], pos);
    assign entry   = win_hit && !pwin_q;

    always_comb begin
      cfg_d    = cfg_q;
      rt_off_d = rt_off_q;
      st_d     = st_q;
      en       = 1'b0;
      pwin_d   = win_hit;
      for (int p = 0; p < pcg_pkg::NPROG; p++) begin
        win_d[p] = win_q[p];
        sp_d[p]  = sp_q[p];
        if (sel && (waddr_q[4:2] == 3'(pcg_pkg::G_WIN0 + 3'(2 * p)))) begin
          win_d[p] = hwdata;
        end
        if (sel && (waddr_q[4:2] == 3'(pcg_pkg::G_SP0 + 3'(2 * p)))) begin
          sp_d[p] = hwdata;
        end
      end
      if (sel && (waddr_q[4:2] == pcg_pkg::G_CFG)) begin
        cfg_d.mode   = hwdata[2:0];
        cfg_d.wvalid = hwdata[pcg_pkg::CFG_WVALID_LSB +: pcg_pkg::NPROG];
      end
      if (sel && (waddr_q[4:2] == pcg_pkg::G_OFF)) begin
        cfg_d.offset = hwdata[pcg_pkg::CFG_OFF_LSB +: pcg_pkg::PW];
      end
      case (cfg_q.mode)
        pcg_pkg::MODE_RESET_EN: begin
          case (st_q)
            pcg_pkg::GS_IDLE: begin
              en = 1'b0;
              if (rise) begin
                // Offset chosen so that the group reads zero next cycle
                rt_off_d = (machine_pos == '0) ? '0 : scale_q - machine_pos;
                st_d     = pcg_pkg::GS_RUN;
              end
            end
            pcg_pkg::GS_RUN: begin
              en = 1'b1;
              if (win_hit) begin
                st_d = pcg_pkg::GS_IDLE;
              end
            end
            default: st_d = pcg_pkg::GS_IDLE;
          endcase
          if (sel && (waddr_q[4:2] == pcg_pkg::G_OFF)) begin
            rt_off_d = hwdata[pcg_pkg::CFG_OFF_LSB +: pcg_pkg::PW];
          end
        end
        pcg_pkg::MODE_LEVEL: begin
          st_d     = pcg_pkg::GS_IDLE;
          en       = sync2_q[g];
          rt_off_d = cfg_d.offset;
        end
        pcg_pkg::MODE_WINDOW: begin
          rt_off_d = cfg_d.offset;
          case (st_q)
            pcg_pkg::GS_IDLE: begin
              if (rise && win_hit) begin
                st_d = pcg_pkg::GS_RUN;
              end
            end
            pcg_pkg::GS_RUN: begin
              en = 1'b1;
              if (entry) begin
                st_d = pcg_pkg::GS_IDLE;
              end
            end
            default: st_d = pcg_pkg::GS_IDLE;
          endcase
        end
        default: begin
          st_d     = pcg_pkg::GS_IDLE;
          rt_off_d = cfg_d.offset;
        end
      endcase
    end

    always_comb begin
      rd = 32'h0000_0000;
      case (haddr[4:2])
        pcg_pkg::G_CFG: begin
          rd[2:0] = cfg_q.mode;
          rd[pcg_pkg::CFG_WVALID_LSB +: pcg_pkg::NPROG] = cfg_q.wvalid;
        end
        pcg_pkg::G_OFF:  rd[pcg_pkg::PW-1:0] = cfg_q.offset;
        pcg_pkg::G_STAT: begin
          rd[pcg_pkg::PW-1:0]        = pos;
          rd[pcg_pkg::GST_EN_BIT]    = en;
          rd[pcg_pkg::GST_RUN_BIT]   = st_q;
          rd[pcg_pkg::GST_CHAN_LSB +: 8] = pcg_pkg::WIN_CHAN_FIRST + 8'(g);
        end
        default: begin
          for (int p = 0; p < pcg_pkg::NPROG; p++) begin
            if (haddr[4:2] == 3'(pcg_pkg::G_WIN0 + 3'(2 * p))) begin
              rd = win_q[p];
            end
            if (haddr[4:2] == 3'(pcg_pkg::G_SP0 + 3'(2 * p))) begin
              rd = sp_q[p];
            end
          end
        end
      endcase
    end

    assign grp_rd[g] = rd;
    assign en_vec[g] = en;
    // Motion gating sits last so it can veto every mode
    assign cam_d[g]  = en && motion_qualified_gating[g] && in_span(sp_q[prog_q], pos);

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cfg_q    <= '0;
        st_q     <= pcg_pkg::GS_IDLE;
        rt_off_q <= '0;
        pwin_q   <= 1'b0;
        for (int p = 0; p < pcg_pkg::NPROG; p++) begin
          win_q[p] <= '0;
          sp_q[p]  <= '0;
        end
      end else begin
        cfg_q    <= cfg_d;
        st_q     <= st_d;
        rt_off_q <= rt_off_d;
        pwin_q   <= pwin_d;
        for (int p = 0; p < pcg_pkg::NPROG; p++) begin
          win_q[p] <= win_d[p];
          sp_q[p]  <= sp_d[p];
        end
      end
    end
  end

endmodule : pcg_cam_groups
`default_nettype wire

// >>> tb/pcg_cam_groups_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_cam_groups_sva (
  input wire logic                     hclk,
  input wire logic                     hresetn,
  input wire logic                     hsel,
  input wire logic [31:0]              haddr,
  input wire logic [1:0]               htrans,
  input wire logic                     hwrite,
  input wire logic [31:0]              hwdata,
  input wire logic                     hready,
  input wire logic                     hreadyout,
  input wire logic [31:0]              hrdata,
  input wire logic                     hresp,
  input wire logic [pcg_pkg::NGRP-1:0] grp_enable_in,
  input wire logic [pcg_pkg::NGRP-1:0] motion_qualified_gating,
  input wire logic [pcg_pkg::NGRP-1:0] cam_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----
  // Mode shadow, rebuilt from bus writes
  // ----
  logic        wr_q, wr_d;
  logic [11:0] wa_q, wa_d;
  logic [23:0] mode_q, mode_d;
  logic [7:0]  seen_q, seen_d;
  always_comb begin
    wr_d   = hsel && htrans[1] && hready && hwrite;
    wa_d   = haddr[11:0];
    mode_d = mode_q;
    seen_d = seen_q;
    if (wr_q && wa_q[11:8] == pcg_pkg::GRP_BASE_HI && wa_q[4:0] == 5'h00) begin
      mode_d[wa_q[7:5]*3 +: 3] = hwdata[2:0];
    end
    for (int g = 0; g < 8; g++) begin
      if (mode_q[g*3 +: 3] inside {3'h2, 3'h4} && grp_enable_in[g]) begin
        seen_d[g] = 1'b1;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      wa_q   <= 12'h000;
      mode_q <= 24'h000000;
      seen_q <= 8'h00;
    end else begin
      wr_q   <= wr_d;
      wa_q   <= wa_d;
      mode_q <= mode_d;
      seen_q <= seen_d;
    end
  end
  // ----
  // Checks
  // ----
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_rdata_idle: assert property (!$past(hsel && htrans[1] && hready && !hwrite) |-> hrdata == 32'h0)
    else $error("read data without read");
  for (genvar g = 0; g < 8; g++) begin : gen_grp
    logic [2:0] m;
    assign m = mode_q[g*3 +: 3];
    sequence s_low;
      m == 3'h3 && !grp_enable_in[g];
    endsequence
    a_level_off: assert property (s_low [*5] |-> !cam_out[g])
      else $error("level group output on with input low");
    a_level_src: assert property (cam_out[g] && m == 3'h3 |-> ($past(grp_enable_in[g], 2) ||
      $past(grp_enable_in[g], 3) || $past(grp_enable_in[g], 4) || $past(grp_enable_in[g], 5)))
      else $error("level group output without input");
    a_edge_needed: assert property (m inside {3'h2, 3'h4} && !seen_q[g] |-> !cam_out[g])
      else $error("edge group output before any input");
    a_disabled_off: assert property (!(m inside {3'h2, 3'h3, 3'h4}) [*3] |-> !cam_out[g])
      else $error("disabled group output on");
    a_motion_gate: assert property (!motion_qualified_gating[g] |=> !cam_out[g])
      else $error("output on without motion");
  end
endmodule : pcg_cam_groups_sva
bind pcg_cam_groups pcg_cam_groups_sva i_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .grp_enable_in(grp_enable_in),
  .motion_qualified_gating(motion_qualified_gating), .cam_out(cam_out));
`default_nettype wire

// >>> tb/pcg_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_sensor_model (
  input  wire logic [pcg_pkg::NGRP-1:0] req,
  output logic      [pcg_pkg::NGRP-1:0] grp_enable_in
);
  // Field wiring switches off the clock grid
  assign #3 grp_enable_in = req;
endmodule : pcg_sensor_model
`default_nettype wire

// >>> tb/pcg_cam_groups_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_cam_groups_tb_top;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r, hr_pre;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] mpos, m0, off;
  logic [7:0]  sens, gen, motion, cam;
  int          error_cnt, total_checks;
  assign hready = hreadyout;
  pcg_cam_groups i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .machine_pos(mpos), .grp_enable_in(gen),
    .motion_qualified_gating(motion), .cam_out(cam));
  pcg_sensor_model i_sens (.req(sens), .grp_enable_in(gen));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Read data as it stands just before the edge, free of the update race at that edge
  always @(negedge hclk) begin
    hr_pre = hrdata;
  end
  // ----
  // Helpers
  // ----
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wrdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        error_cnt++;
        test_done();
      end
      @(posedge hclk);
    end
  endtask : wrdy
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {20'h0, a};
    wrdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wrdy();
    r = hr_pre;
  endtask : bus
  function automatic logic [11:0] ga(input int g, input logic [2:0] o);
    return 12'(32'h100 + g * 32 + o * 4);
  endfunction : ga
  function automatic logic [15:0] adv(input logic [15:0] b, input int d);
    return 16'((b + d) % pcg_pkg::SCALE_RST);
  endfunction : adv
  task automatic gw(input int g, input logic [2:0] o, input logic [31:0] d);
    bus(1'b1, ga(g, o), d);
  endtask : gw
  // Several reads give the two sync flops and the output flop time to land
  task automatic gpos(input int g);
    repeat (3) bus(1'b0, ga(g, pcg_pkg::G_STAT), 32'h0);
  endtask : gpos
  task automatic wrun(input int g, input logic v);
    for (int n = 0; n < 20; n++) begin
      bus(1'b0, ga(g, pcg_pkg::G_STAT), 32'h0);
      if (r[pcg_pkg::GST_RUN_BIT] === v) return;
    end
    error_cnt++;
    test_done();
  endtask : wrun
  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(32'h2ad37bf1));
    {hsel, hwrite, htrans, haddr, hwdata, sens} = '0;
    {hresetn, hsize, motion} = {1'b0, 3'h2, 8'hff};
    {error_cnt, total_checks} = '0;
    mpos = 16'($urandom_range(359));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, pcg_pkg::A_CTRL, 32'h0);
    check(r, {16'h0, pcg_pkg::SCALE_RST});
    bus(1'b0, 12'hffc, 32'h0);
    check(r, 32'h0);
    for (int g = 0; g < 8; g++) begin
      gpos(g);
      check({r[31:24], 8'h0, r[15:0]}, {pcg_pkg::WIN_CHAN_FIRST + 8'(g), 8'h0, mpos});
    end
    $display("test reset_map done");
    gw(0, pcg_pkg::G_WIN0, {16'd359, 16'd355});
    gw(0, pcg_pkg::G_SP0, {16'd100, 16'd10});
    gw(0, pcg_pkg::G_CFG, 32'h102);
    m0 = 16'($urandom_range(359));
    mpos <= m0;
    sens[0] <= 1'b1;
    wrun(0, 1'b1);
    gpos(0);
    check({r[15:0], 7'h0, cam[0]}, 24'h0);
    mpos <= adv(m0, 50);
    gpos(0);
    check({r[15:0], 7'h0, cam[0]}, {16'd50, 8'h1});
    sens[0] <= 1'b0;
    gpos(0);
    sens[0] <= 1'b1;
    gpos(0);
    check(r[15:0], 16'd50);
    mpos <= adv(m0, 357);
    wrun(0, 1'b0);
    mpos <= adv(m0, 50);
    gpos(0);
    check(cam[0], 1'b0);
    sens[0] <= 1'b0;
    gpos(0);
    sens[0] <= 1'b1;
    wrun(0, 1'b1);
    $display("test reset_enable done");
    off = 16'($urandom_range(359));
    gw(1, pcg_pkg::G_OFF, {16'h0, off});
    gw(1, pcg_pkg::G_SP0, {16'd359, 16'd0});
    gw(1, pcg_pkg::G_CFG, 32'h3);
    for (int i = 0; i < 4; i++) begin
      mpos <= 16'($urandom_range(359));
      gpos(1);
      check(r[15:0], adv(mpos, off));
    end
    check(cam[1], 1'b0);
    sens[1] <= 1'b1;
    gpos(1);
    check(cam[1], 1'b1);
    motion[1] <= 1'b0;
    gpos(1);
    check(cam[1], 1'b0);
    motion[1] <= 1'b1;
    sens[1] <= 1'b0;
    gpos(1);
    check({r[15:0], 7'h0, cam[1]}, {adv(mpos, off), 8'h0});
    $display("test level done");
    gw(2, pcg_pkg::G_WIN0, {16'd60, 16'd50});
    gw(2, pcg_pkg::G_SP0, {16'd359, 16'd0});
    gw(2, pcg_pkg::G_CFG, 32'h104);
    mpos <= 16'd100;
    sens[2] <= 1'b1;
    gpos(2);
    check({r[pcg_pkg::GST_RUN_BIT], cam[2]}, 2'b00);
    sens[2] <= 1'b0;
    mpos <= 16'd55;
    gpos(2);
    sens[2] <= 1'b1;
    wrun(2, 1'b1);
    mpos <= 16'd200;
    gpos(2);
    check({r[15:0], 7'h0, cam[2]}, {16'd200, 8'h1});
    mpos <= 16'd50;
    wrun(2, 1'b0);
    gpos(2);
    check(cam[2], 1'b0);
    $display("test window done");
    gw(3, pcg_pkg::G_CFG, 32'h2);
    sens[3] <= 1'b1;
    wrun(3, 1'b1);
    mpos <= adv(mpos, 357);
    gpos(3);
    check(r[pcg_pkg::GST_RUN_BIT], 1'b1);
    gw(3, pcg_pkg::G_WIN0 + 3'h2, {16'd359, 16'd0});
    gw(3, pcg_pkg::G_CFG, 32'h202);
    bus(1'b1, pcg_pkg::A_CTRL, {15'h0, 1'b1, pcg_pkg::SCALE_RST});
    wrun(3, 1'b0);
    $display("test programs done");
    test_done();
  end
endmodule : pcg_cam_groups_tb_top
`default_nettype wire
